// ### passthru_pkg.sv
// constants and carrier types for the uart passthrough and power feature logic
// assumes an 8-bit register engine with 6-bit ulpi register addresses
package passthru_pkg;
    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [5:0] UART_CTRL_WR_ADDR = 6'h19;
    localparam logic [5:0] UART_CTRL_SET_ADDR = 6'h1a;
    localparam logic [5:0] UART_CTRL_CLR_ADDR = 6'h1b;
    localparam logic [5:0] POWER_FEATURE_CONTROL_WR_ADDR = 6'h3d;
    localparam logic [5:0] POWER_FEATURE_CONTROL_SET_ADDR = 6'h3e;
    localparam logic [5:0] POWER_FEATURE_CONTROL_CLR_ADDR = 6'h3f;
    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int RXD_ROUTE_BIT = 3;
    localparam int TXD_ROUTE_BIT = 2;
    localparam int WEAK_PULLUP_BIT = 4;
    localparam int BVALID_FALL_BIT = 3;
    localparam int BVALID_RISE_BIT = 2;
    localparam logic [7:0] UART_CTRL_RESET = 8'h00;
    localparam logic [7:0] POWER_FEATURE_CONTROL_RESET = 8'h00;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_UART = 2'b01,
        MODE_LEAVING = 2'b11
    } pt_mode_t;
endpackage

// ### uart_passthru_power_ctrl.sv
// uart passthrough routing and power feature register of the transceiver
// assumes the ulpi register engine and interface control register run on core_clk;
// stp, data0, dp, bvalid and the a-session comparator are asynchronous pins/levels
//
// What this block does
// - uart control acts only in passthrough mode
// - no normal ulpi while in passthrough
// - stp or chip-select reset ends passthrough
// - rx route: dp copied to data1
// - tx route: data0 copied to dm
// - route bits clear on passthrough exit
// - pull-up bit enables pull-up above a-session
// - passthrough forces the weak pull-up on
// - bvalid fall sends rxcmd with alternate_interrupt_flag
// - bvalid rise sends rxcmd with alternate_interrupt_flag
// - bvalid edge enables reset disabled
// - uart control at 19h/1ah/1bh
// - power control at 3dh/3eh/3fh
`timescale 1ns/100ps
module uart_passthru_power_ctrl
    import passthru_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire reg_req_t reg_req,
    input wire logic [5:0] reg_rd_addr,
    output logic [7:0] reg_rdata,
    input wire logic passthru_mode_bit,
    output logic passthru_mode_clear,
    output logic ulpi_link_enable,
    input wire logic stp_pin,
    input wire logic data0_pin,
    output pin_drive_t data1_drive,
    input wire logic dp_pin,
    output pin_drive_t dm_drive,
    input wire logic bvalid_level,
    input wire logic a_session_valid_threshold,
    output logic dplus_weak_pullup_enable,
    output logic rxcmd_req,
    output logic alternate_interrupt_flag,
    input wire logic rxcmd_ack
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // bit order: stp, data0, dp, bvalid, a-session
    logic [4:0] async_in;
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic stp_s;
    logic data0_s;
    logic dp_s;
    logic bvalid_s;
    logic asess_s;

    assign async_in = {stp_pin, data0_pin, dp_pin, bvalid_level, a_session_valid_threshold};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= async_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    assign {stp_s, data0_s, dp_s, bvalid_s, asess_s} = sync2_q;

    // ----------------------------------------
    // passthrough mode sequencing
    // ----------------------------------------
    pt_mode_t mode_q;
    pt_mode_t mode_d;
    logic mode_clear_q;
    logic mode_clear_d;
    logic in_uart;

    assign in_uart = (mode_q == MODE_UART);

    always_comb begin
        mode_d = mode_q;
        mode_clear_d = 1'b0;
        case (mode_q)
            MODE_NORMAL: begin
                if (passthru_mode_bit) begin
                    mode_d = MODE_UART;
                end
            end
            MODE_UART: begin
                // stp ends passthrough; the interface control bit is cleared outside
                if (stp_s || !passthru_mode_bit) begin
                    mode_d = MODE_LEAVING;
                    mode_clear_d = 1'b1;
                end
            end
            MODE_LEAVING: begin
                // wait for the mode bit to drop so a held bit cannot re-enter at once
                mode_clear_d = passthru_mode_bit;
                if (!passthru_mode_bit) begin
                    mode_d = MODE_NORMAL;
                end
            end
            default: begin
                mode_d = MODE_NORMAL;
            end
        endcase
    end

    // srst also stands for the chip-select hardware reset
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mode_q <= MODE_NORMAL;
            mode_clear_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            mode_clear_q <= mode_clear_d;
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic [7:0] uart_ctrl_q;
    logic [7:0] uart_ctrl_d;
    logic [7:0] power_feature_control_q;
    logic [7:0] power_feature_control_d;

    function automatic logic [7:0] rwsc(input logic [7:0] cur, input reg_req_t req,
                                        input logic [5:0] wr_addr, input logic [5:0] set_addr,
                                        input logic [5:0] clr_addr);
        logic [7:0] nxt;
        nxt = cur;
        if (req.wr) begin
            if (req.addr == wr_addr) begin
                nxt = req.wdata;
            end else if (req.addr == set_addr) begin
                nxt = cur | req.wdata;
            end else if (req.addr == clr_addr) begin
                nxt = cur & ~req.wdata;
            end
        end
        return nxt;
    endfunction

    always_comb begin
        uart_ctrl_d = rwsc(uart_ctrl_q, reg_req, UART_CTRL_WR_ADDR, UART_CTRL_SET_ADDR,
                           UART_CTRL_CLR_ADDR);
        power_feature_control_d = rwsc(power_feature_control_q, reg_req, POWER_FEATURE_CONTROL_WR_ADDR, POWER_FEATURE_CONTROL_SET_ADDR,
                          POWER_FEATURE_CONTROL_CLR_ADDR);
        // leaving passthrough drops both routes, overriding a write in the same cycle
        if (mode_q == MODE_LEAVING || mode_clear_d) begin
            uart_ctrl_d[RXD_ROUTE_BIT] = 1'b0;
            uart_ctrl_d[TXD_ROUTE_BIT] = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            uart_ctrl_q <= UART_CTRL_RESET;
            power_feature_control_q <= POWER_FEATURE_CONTROL_RESET;
        end else begin
            uart_ctrl_q <= uart_ctrl_d;
            power_feature_control_q <= power_feature_control_d;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb begin
        case (reg_rd_addr)
            UART_CTRL_WR_ADDR, UART_CTRL_SET_ADDR, UART_CTRL_CLR_ADDR: rdata_d = uart_ctrl_q;
            POWER_FEATURE_CONTROL_WR_ADDR, POWER_FEATURE_CONTROL_SET_ADDR, POWER_FEATURE_CONTROL_CLR_ADDR: rdata_d = power_feature_control_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // routing and pull-up
    // ----------------------------------------
    pin_drive_t data1_q;
    pin_drive_t data1_d;
    pin_drive_t dm_q;
    pin_drive_t dm_d;
    logic link_en_q;
    logic link_en_d;
    logic pullup_q;
    logic pullup_d;

    always_comb begin
        // routes are gated by the mode so a stale bit never drives a pin
        data1_d.oe = in_uart && uart_ctrl_q[RXD_ROUTE_BIT];
        data1_d.out = data1_d.oe && dp_s;
        dm_d.oe = in_uart && uart_ctrl_q[TXD_ROUTE_BIT];
        dm_d.out = dm_d.oe && data0_s;
        link_en_d = (mode_q == MODE_NORMAL);
        pullup_d = in_uart || (power_feature_control_q[WEAK_PULLUP_BIT] && asess_s);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            data1_q <= '0;
            dm_q <= '0;
            link_en_q <= 1'b1;
            pullup_q <= 1'b0;
        end else begin
            data1_q <= data1_d;
            dm_q <= dm_d;
            link_en_q <= link_en_d;
            pullup_q <= pullup_d;
        end
    end

    // ----------------------------------------
    // bvalid edge reporting
    // ----------------------------------------
    logic bvalid_prev_q;
    logic pend_q;
    logic pend_d;
    logic edge_evt;

    always_comb begin
        edge_evt = (power_feature_control_q[BVALID_FALL_BIT] && bvalid_prev_q && !bvalid_s)
                || (power_feature_control_q[BVALID_RISE_BIT] && !bvalid_prev_q && bvalid_s);
        // a new edge in the ack cycle keeps the request standing
        pend_d = edge_evt || (pend_q && !rxcmd_ack);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            bvalid_prev_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            bvalid_prev_q <= bvalid_s;
            pend_q <= pend_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata = rdata_q;
    assign passthru_mode_clear = mode_clear_q;
    assign ulpi_link_enable = link_en_q;
    assign data1_drive = data1_q;
    assign dm_drive = dm_q;
    assign dplus_weak_pullup_enable = pullup_q;
    assign rxcmd_req = pend_q;
    assign alternate_interrupt_flag = pend_q;
endmodule

// ### passthru_monitor.sv
// assertions on the passthrough and power feature block
// sees only the top ports; bound into the design below
`timescale 1ns/100ps
module passthru_monitor
    import passthru_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire reg_req_t reg_req,
    input wire logic [5:0] reg_rd_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic passthru_mode_clear,
    input wire logic ulpi_link_enable,
    input wire logic stp_pin,
    input wire logic data0_pin,
    input wire pin_drive_t data1_drive,
    input wire logic dp_pin,
    input wire pin_drive_t dm_drive,
    input wire logic bvalid_level,
    input wire logic dplus_weak_pullup_enable,
    input wire logic rxcmd_req,
    input wire logic alternate_interrupt_flag,
    input wire logic rxcmd_ack
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // ----
    // properties
    // ----
    property p_rst_rd; $past(srst) |-> reg_rdata == 8'h00; endproperty
    property p_unmapped; !(reg_rd_addr inside {[6'h19:6'h1b], [6'h3d:6'h3f]}) |=> reg_rdata == 8'h00; endproperty
    property p_wr_rd;
        reg_req.wr && reg_req.addr == POWER_FEATURE_CONTROL_WR_ADDR ##1 !reg_req.wr && reg_rd_addr == POWER_FEATURE_CONTROL_WR_ADDR
        |=> reg_rdata == $past(reg_req.wdata, 2);
    endproperty
    property p_rx_route; data1_drive.oe |-> data1_drive.out == $past(dp_pin, 3); endproperty
    property p_tx_route; dm_drive.oe |-> dm_drive.out == $past(data0_pin, 3); endproperty
    property p_route_mode; data1_drive.oe || dm_drive.oe |-> !ulpi_link_enable; endproperty
    property p_exit_clr; $rose(passthru_mode_clear) |=> !data1_drive.oe && !dm_drive.oe; endproperty
    property p_stp_exit; $rose(stp_pin) && !ulpi_link_enable && !passthru_mode_clear |-> ##[1:4] passthru_mode_clear;
    endproperty
    property p_pullup_uart; $fell(ulpi_link_enable) |-> dplus_weak_pullup_enable; endproperty
    property p_rxcmd_hold; rxcmd_req && !rxcmd_ack |=> rxcmd_req; endproperty
    property p_alt_flag; alternate_interrupt_flag == rxcmd_req; endproperty
    // two sync flops and the edge flop put the pin change three edges before the request
    property p_edge_src; $rose(rxcmd_req) |-> $past(bvalid_level, 3) != $past(bvalid_level, 4); endproperty
    a_rst_rd: assert property (p_rst_rd) else $error("register not cleared by reset");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_wr_rd: assert property (p_wr_rd) else $error("power register read-back wrong");
    a_rx_route: assert property (p_rx_route) else $error("data1 not following dp");
    a_tx_route: assert property (p_tx_route) else $error("dm not following data0");
    a_route_mode: assert property (p_route_mode) else $error("route active outside passthrough");
    a_exit_clr: assert property (p_exit_clr) else $error("routes kept after exit");
    a_stp_exit: assert property (p_stp_exit) else $error("stop did not end passthrough");
    a_pullup_uart: assert property (p_pullup_uart) else $error("pull-up off in passthrough");
    a_rxcmd_hold: assert property (p_rxcmd_hold) else $error("rxcmd request dropped early");
    a_alt_flag: assert property (p_alt_flag) else $error("alternate_interrupt_flag bit differs from request");
    a_edge_src: assert property (p_edge_src) else $error("rxcmd raised without a bvalid edge");
    c_exit: cover property ($rose(passthru_mode_clear));
    c_rxcmd: cover property (rxcmd_req && rxcmd_ack);
    c_set: cover property (reg_req.wr && reg_req.addr == UART_CTRL_SET_ADDR);
endmodule
bind uart_passthru_power_ctrl passthru_monitor u_mon (.core_clk, .srst, .reg_req, .reg_rd_addr, .reg_rdata,
    .passthru_mode_clear, .ulpi_link_enable, .stp_pin, .data0_pin, .data1_drive, .dp_pin, .dm_drive,
    .bvalid_level, .dplus_weak_pullup_enable, .rxcmd_req, .alternate_interrupt_flag, .rxcmd_ack);

// ### link_model.sv
// link side: interface control mode bit and a slow rxcmd acceptor
// assumes enter_req is a one-cycle pulse from the bench
`timescale 1ns/100ps
module link_model (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic enter_req,
    input wire logic passthru_mode_clear,
    input wire logic rxcmd_req,
    output logic passthru_mode_bit,
    output logic rxcmd_ack
);
    logic [1:0] wait_q;
    // ----
    // mode bit and ack
    // ----
    always_ff @(posedge core_clk) begin
        if (srst) begin
            passthru_mode_bit <= 1'b0;
            rxcmd_ack <= 1'b0;
            wait_q <= 2'h0;
        end else begin
            // the device asks, the link drops the bit
            passthru_mode_bit <= !passthru_mode_clear && (passthru_mode_bit || enter_req);
            // slow acceptor so the request must be held
            rxcmd_ack <= rxcmd_req && !rxcmd_ack && wait_q == 2'h3;
            wait_q <= (rxcmd_req && !rxcmd_ack) ? wait_q + 2'h1 : 2'h0;
        end
    end
endmodule

// ### uart_passthru_power_ctrl_tb.sv
// self-checking bench for the passthrough and power feature block
// assumes link_model and passthru_monitor are compiled alongside
`timescale 1ns/100ps
module uart_passthru_power_ctrl_tb;
    import passthru_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    reg_req_t reg_req = '0;
    logic [5:0] reg_rd_addr = 6'h00;
    logic stp_pin = 1'b0, data0_pin = 1'b0, dp_pin = 1'b0, bvalid_level = 1'b0;
    logic a_session_valid_threshold = 1'b0, enter_req = 1'b0;
    logic [7:0] reg_rdata;
    logic passthru_mode_bit, passthru_mode_clear, ulpi_link_enable, rxcmd_req, rxcmd_ack;
    logic dplus_weak_pullup_enable, alternate_interrupt_flag;
    pin_drive_t data1_drive, dm_drive;
    int err_total = 0, checks_done = 0, cycles = 0;
    always #25 core_clk = ~core_clk;
    uart_passthru_power_ctrl u_dut (.core_clk, .srst, .reg_req, .reg_rd_addr, .reg_rdata, .passthru_mode_bit,
        .passthru_mode_clear, .ulpi_link_enable, .stp_pin, .data0_pin, .data1_drive, .dp_pin, .dm_drive,
        .bvalid_level, .a_session_valid_threshold, .dplus_weak_pullup_enable, .rxcmd_req,
        .alternate_interrupt_flag, .rxcmd_ack);
    link_model u_link (.core_clk, .srst, .enter_req, .passthru_mode_clear, .rxcmd_req, .passthru_mode_bit,
        .rxcmd_ack);
    // ----
    // helpers
    // ----
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge core_clk) reg_req = '{1'b1, a, d};
        @(negedge core_clk) reg_req.wr = 1'b0;
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
        @(negedge core_clk) reg_rd_addr = a;
        @(negedge core_clk) chk(reg_rdata, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic give_verdict();
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_regs();
        rdchk(UART_CTRL_WR_ADDR, UART_CTRL_RESET);
        rdchk(POWER_FEATURE_CONTROL_CLR_ADDR, POWER_FEATURE_CONTROL_RESET);
        rdchk(6'h20, 8'h00);
        wr(POWER_FEATURE_CONTROL_WR_ADDR, 8'h04);
        wr(POWER_FEATURE_CONTROL_SET_ADDR, 8'h18);
        rdchk(POWER_FEATURE_CONTROL_SET_ADDR, 8'h1c);
        wr(POWER_FEATURE_CONTROL_CLR_ADDR, 8'h0c);
        rdchk(POWER_FEATURE_CONTROL_CLR_ADDR, 8'h10);
        wr(UART_CTRL_SET_ADDR, 8'h0c);
        rdchk(UART_CTRL_SET_ADDR, 8'h0c);
        cyc(4);
        chk(dm_drive.oe, 1'b0);
        chk(data1_drive.oe, 1'b0);
        wr(UART_CTRL_CLR_ADDR, 8'h0c);
        rdchk(UART_CTRL_CLR_ADDR, 8'h00);
    endtask
    task automatic t_pullup();
        a_session_valid_threshold = 1'b1;
        cyc(5);
        chk(dplus_weak_pullup_enable, 1'b1);
        wr(POWER_FEATURE_CONTROL_CLR_ADDR, 8'h10);
        cyc(3);
        chk(dplus_weak_pullup_enable, 1'b0);
    endtask
    task automatic t_uart(input logic by_stop);
        enter_req = 1'b1;
        cyc(1);
        enter_req = 1'b0;
        cyc(3);
        chk(ulpi_link_enable, 1'b0);
        chk(dplus_weak_pullup_enable, 1'b1);
        wr(UART_CTRL_SET_ADDR, 8'h0c);
        dp_pin = 1'b1;
        // a second pass finds data0 left high by the first one
        data0_pin = 1'b0;
        cyc(4);
        chk(data1_drive, 2'b11);
        chk(dm_drive, 2'b01);
        dp_pin = 1'b0;
        data0_pin = 1'b1;
        cyc(4);
        chk(data1_drive, 2'b01);
        chk(dm_drive, 2'b11);
        // chip-select reset is the second way out
        stp_pin = by_stop;
        srst = !by_stop;
        cyc(by_stop ? 3 : 1);
        srst = 1'b0;
        chk(passthru_mode_clear, by_stop);
        cyc(by_stop ? 3 : 0);
        chk(dm_drive.oe, 1'b0);
        rdchk(UART_CTRL_WR_ADDR, 8'h00);
        stp_pin = 1'b0;
        cyc(3);
        chk(ulpi_link_enable, 1'b1);
    endtask
    task automatic t_bvalid();
        bvalid_level = 1'b1;
        cyc(6);
        chk(rxcmd_req, 1'b0);
        bvalid_level = 1'b0;
        cyc(6);
        wr(POWER_FEATURE_CONTROL_SET_ADDR, 8'h04);
        bvalid_level = 1'b1;
        cyc(5);
        chk(alternate_interrupt_flag, 1'b1);
        cyc(8);
        chk(rxcmd_req, 1'b0);
        // read address left on the power register so the write shows on rdata
        rdchk(POWER_FEATURE_CONTROL_WR_ADDR, 8'h04);
        wr(POWER_FEATURE_CONTROL_WR_ADDR, 8'h08);
        bvalid_level = 1'b0;
        cyc(5);
        chk(alternate_interrupt_flag, 1'b1);
        rdchk(POWER_FEATURE_CONTROL_WR_ADDR, 8'h08);
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        cyc(3);
        srst = 1'b0;
        t_regs();
        t_pullup();
        t_uart(1'b1);
        t_uart(1'b0);
        t_bvalid();
        give_verdict();
    end
endmodule
